// ==== core/tbpwm_top.sv ====
// Ten-bit PWM pair with three 8-bit timers, timer select and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tbpwm_map.svh"
module tbpwm_top
  import tbpwm_pkg::*;
#(
  parameter int NCHAN = 2  // PWM channels
)(
  input  wire logic        i_clk,      // 250 MHz system clock
  input  wire logic        i_nrst,     // Sync reset, active low
  input  wire logic        i_sleep,    // Device sleep request
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [11:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic             pready,     // APB ready
  output logic [31:0]      prdata,     // APB read data
  output logic             pslverr,    // APB error on unmapped address
  output logic [1:0]       o_ccp1_sel, // CCP1 timer pair select
  output logic [1:0]       o_ccp2_sel, // CCP2 timer pair select
  output logic [NCHAN-1:0] o_pwm       // PWM outputs
);
  // Elaboration check: the register map serves exactly two channels
  if (NCHAN != 2) begin : g_bad_nchan
    $error("tbpwm_top supports two channels");
  end

  // Timer mapping: index 0/1/2 = timers A/B/C
  typedef struct packed {
    tbpwm_bus_t  bus;          // Bus handshake state
    logic [31:0] rdata;        // Read data register
    logic        err;          // Error response
    logic [7:0]  tsel;         // Timer select register
    logic [1:0]  en;           // Channel enables
    logic [1:0]  output_invert;          // Channel polarities
    logic [19:0] duty;         // Duty values, channel 1 high
    logic [23:0] period;       // Period values per timer
    logic [23:0] count;        // Timer counts
    logic [5:0]  sub;          // Two low time base bits per timer
    logic [17:0] pre;          // Prescale counters per timer
    logic [17:0] prediv;       // Prescale selects, value minus one
    logic [2:0]  ton;          // Timer run bits
    logic [2:0]  sl_s1;        // Sleep pin synchroniser
    logic        sleep;        // Filtered sleep
  } tbpwm_st_t;
  tbpwm_st_t s_q, s_d;

  logic [9:0]      tbase  [3];  // Per-timer ten-bit time base
  logic [2:0]      wrap;        // Timer wraps this cycle
  logic [2:0]      run;         // Timer advances this cycle
  logic [NCHAN-1:0] chan_out;   // Channel levels

  // Map a two-bit select to a timer index, reserved to A
  function automatic logic [1:0] sel_idx(input logic [1:0] s);
    sel_idx = (s == TBPWM_SEL_RSVD) ? 2'd0 : s - 2'd1;
  endfunction : sel_idx

  // Per-timer time base and wrap detect
  for (genvar t = 0; t < 3; t++) begin : g_tmr
    assign tbase[t] = {s_q.count[t*8 +: 8], s_q.sub[t*2 +: 2]};
    assign run[t]   = s_q.ton[t] && !s_q.sleep && s_q.pre[t*6 +: 6] == s_q.prediv[t*6 +: 6];
    assign wrap[t]  = run[t] && s_q.sub[t*2 +: 2] == 2'h3
                      && s_q.count[t*8 +: 8] == s_q.period[t*8 +: 8];
  end

  // Each channel takes the period of its own selected timer, own duty
  for (genvar c = 0; c < NCHAN; c++) begin : g_ch
    logic [1:0] ti;
    assign ti = sel_idx(s_q.tsel[4+2*c +: 2]);
    tbpwm_chan u_chan (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_en     (s_q.en[c]),
      .i_pol    (s_q.output_invert[c]),
      .i_duty   (s_q.duty[c*10 +: 10]),
      .i_tbase  (tbase[ti]),
      .i_period (s_q.period[ti*8 +: 8]),
      .i_reload (wrap[ti]),
      .i_run    (run[ti] && !s_q.sleep),
      .o_out    (chan_out[c])
    );
  end

  // Register read mux
  function automatic logic [31:0] rd_mux(input tbpwm_st_t s, input logic [11:0] a,
                                         input logic [1:0] lv, output logic hit);
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    if (a == `TBPWM_OFS_TSEL) begin
      rd_mux[7:0] = s.tsel;
    end else if (a == `TBPWM_OFS_TIMER_IF) begin
      rd_mux = {8'h00, s.prediv[17:12], s.prediv[11:6], s.prediv[5:0], 1'b0, s.ton, 2'h0};
    end else if (a == `TBPWM_OFS_CTRL0 || a == `TBPWM_OFS_CTRL1) begin
      rd_mux[`TBPWM_BIT_EN]  = (a == `TBPWM_OFS_CTRL0) ? s.en[0] : s.en[1];
      rd_mux[`TBPWM_BIT_OUT] = (a == `TBPWM_OFS_CTRL0) ? lv[0] : lv[1];
      rd_mux[`TBPWM_BIT_POL] = (a == `TBPWM_OFS_CTRL0) ? s.output_invert[0] : s.output_invert[1];
    end else if (a == `TBPWM_OFS_DUTY0) begin
      rd_mux[15:0] = {s.duty[9:2], s.duty[1:0], 6'h00};
      rd_mux[31:24] = s.period[7:0];
    end else if (a == `TBPWM_OFS_DUTY1) begin
      rd_mux[15:0] = {s.duty[19:12], s.duty[11:10], 6'h00};
      rd_mux[31:24] = s.period[15:8];
    end else begin
      hit = 1'b0;
    end
  endfunction : rd_mux

  // Next state: APB slave, timers, sleep filter
  always_comb begin
    logic hit;
    logic [31:0] rd;
    logic acc;
    hit = 1'b0;
    s_d = s_q;
    rd  = rd_mux(s_q, paddr, chan_out, hit);
    acc = psel && penable && s_q.bus == TBPWM_ST_ACCESS;
    // Sleep pin: change counts when stages two and three agree
    s_d.sl_s1 = {s_q.sl_s1[1:0], i_sleep};
    if (s_q.sl_s1[1] == s_q.sl_s1[2]) s_d.sleep = s_q.sl_s1[2];
    // Bus handshake: one wait state then ready
    case (s_q.bus)
      TBPWM_ST_IDLE:   if (psel && !penable) s_d.bus = TBPWM_ST_ACCESS;
      TBPWM_ST_ACCESS: if (psel && penable) begin
        s_d.bus   = TBPWM_ST_DONE;
        s_d.rdata = pwrite ? 32'h0000_0000 : rd;
        s_d.err   = !hit;
      end
      TBPWM_ST_DONE:   s_d.bus = TBPWM_ST_IDLE;
      default:         s_d.bus = TBPWM_ST_IDLE;
    endcase
    // Timers: prescaler, two low bits, count; postscaler absent
    for (int t = 0; t < 3; t++) begin
      if (s_q.ton[t] && !s_q.sleep) begin
        s_d.pre[t*6 +: 6] = run[t] ? 6'h00 : s_q.pre[t*6 +: 6] + 6'h01;
        if (run[t]) begin
          s_d.sub[t*2 +: 2] = s_q.sub[t*2 +: 2] + 2'h1;
          if (wrap[t]) s_d.count[t*8 +: 8] = 8'h00;
          else if (s_q.sub[t*2 +: 2] == 2'h3) s_d.count[t*8 +: 8] = s_q.count[t*8 +: 8] + 8'h01;
        end
      end
    end
    // Register writes take effect at the access edge
    if (acc && pwrite && hit) begin
      if (paddr == `TBPWM_OFS_TSEL) begin
        s_d.tsel = pwdata[7:0];
      end else if (paddr == `TBPWM_OFS_TIMER_IF) begin
        s_d.ton    = pwdata[4:2];
        s_d.prediv = pwdata[23:6];
      end else if (paddr == `TBPWM_OFS_CTRL0) begin
        s_d.en[0]  = pwdata[`TBPWM_BIT_EN];
        s_d.output_invert[0] = pwdata[`TBPWM_BIT_POL];
      end else if (paddr == `TBPWM_OFS_CTRL1) begin
        s_d.en[1]  = pwdata[`TBPWM_BIT_EN];
        s_d.output_invert[1] = pwdata[`TBPWM_BIT_POL];
      end else if (paddr == `TBPWM_OFS_DUTY0) begin
        s_d.duty[9:0]   = {pwdata[15:8], pwdata[7:6]};
        s_d.period[7:0] = pwdata[31:24];
      end else if (paddr == `TBPWM_OFS_DUTY1) begin
        s_d.duty[19:10]  = {pwdata[15:8], pwdata[7:6]};
        s_d.period[15:8] = pwdata[31:24];
      end
    end
  end

  // State register with reset values
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_q        <= '0;
      s_q.bus    <= TBPWM_ST_IDLE;
      s_q.tsel   <= `TBPWM_TSEL_RST;
      s_q.period <= {3{`TBPWM_PERIOD_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign pready     = (s_q.bus == TBPWM_ST_DONE);
  assign prdata     = s_q.rdata;
  assign pslverr    = (s_q.bus == TBPWM_ST_DONE) && s_q.err;
  assign o_ccp1_sel = s_q.tsel[1:0];
  assign o_ccp2_sel = s_q.tsel[3:2];
  assign o_pwm      = chan_out;

  AST_TSEL_RESET: assert property (@(posedge i_clk)
    $rose(i_nrst) |-> s_q.tsel == 8'h55) else $error("select reset wrong");
  AST_SLEEP_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.sleep && $past(s_q.sleep)) |-> $stable(s_q.count) && $stable(o_pwm)) else $error("sleep not frozen");
  AST_WRAP_CLEARS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wrap[0] |=> s_q.count[7:0] == 8'h00) else $error("wrap left count");
  AST_READY_ONE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pready |=> !pready) else $error("ready longer than one cycle");
  AST_FULL_DUTY: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.en[0] && !s_q.output_invert[0] && g_ch[0].ti == 2'd0 && s_q.duty[9:2] >= s_q.period[7:0]
     && o_pwm[0] && !wrap[0] && !s_q.sleep) |=> o_pwm[0] || $past(s_q.duty[9:0] == 10'h000))
    else $error("full duty cleared");
  COV_WRAP: cover property (@(posedge i_clk) wrap[0]);
  COV_SLEEP: cover property (@(posedge i_clk) s_q.sleep);
  COV_ERR: cover property (@(posedge i_clk) pslverr);
endmodule : tbpwm_top
`default_nettype wire

// ==== core/tbpwm_map.svh ====
// Register offsets, field positions, reset values and timing constants of the PWM block
`ifndef TBPWM_MAP_SVH
`define TBPWM_MAP_SVH
`define TBPWM_OFS_TSEL      12'hFAD
`define TBPWM_OFS_TIMER_IF  12'hF00
`define TBPWM_OFS_CTRL0     12'hF04
`define TBPWM_OFS_DUTY0     12'hF08
`define TBPWM_OFS_CTRL1     12'hF0C
`define TBPWM_OFS_DUTY1     12'hF10
`define TBPWM_TSEL_RST      8'h55
`define TBPWM_BIT_EN        7
`define TBPWM_BIT_OUT       5
`define TBPWM_BIT_POL       4
`define TBPWM_TIF_BIT_SLEEP 0
`define TBPWM_TIF_PRE_LSB   8
`define TBPWM_PERIOD_RST    8'hFF
`define TBPWM_QUARTER_NS    4
`endif

// ==== core/tbpwm_pkg.sv ====
// Types shared by the PWM block
package tbpwm_pkg;
  typedef enum logic [1:0] {
    TBPWM_SEL_RSVD = 2'h0,
    TBPWM_SEL_A    = 2'h1,
    TBPWM_SEL_B    = 2'h2,
    TBPWM_SEL_C    = 2'h3
  } tbpwm_sel_t;
  typedef enum logic [2:0] {
    TBPWM_ST_IDLE   = 3'b001,
    TBPWM_ST_ACCESS = 3'b010,
    TBPWM_ST_DONE   = 3'b100
  } tbpwm_bus_t;
endpackage : tbpwm_pkg

// ==== core/tbpwm_chan.sv ====
// One PWM channel: buffered duty, compare, set/clear and polarity
`timescale 1ns/1ps
`default_nettype none
module tbpwm_chan
  import tbpwm_pkg::*;
(
  input  wire logic       i_clk,      // System clock
  input  wire logic       i_nrst,     // Sync reset, active low
  input  wire logic       i_en,       // Channel enable
  input  wire logic       i_pol,      // Output invert
  input  wire logic [9:0] i_duty,     // Software duty value
  input  wire logic [9:0] i_tbase,    // Selected 10-bit time base
  input  wire logic [7:0] i_period,   // Selected period value
  input  wire logic       i_reload,   // Period wrap of selected timer
  input  wire logic       i_run,      // Time base advances this cycle
  output logic            o_out       // Driven level after polarity
);
  typedef struct packed {
    logic [9:0] dbuf;   // Active duty buffer
    logic       raw;    // Set/clear level before polarity
  } tbpwm_cst_t;
  tbpwm_cst_t s_q, s_d;

  // Next state: set on wrap unless duty is zero, clear on match or when disabled, hold otherwise
  always_comb begin
    s_d = s_q;
    if (!i_en) begin
      s_d.raw = 1'b0;
      if (i_reload) s_d.dbuf = i_duty;
    end else if (i_run) begin
      if (i_reload) begin
        s_d.dbuf = i_duty;
        s_d.raw  = (i_duty != 10'h000);
      // Clear as the time base steps onto the duty value, so the pulse lasts exactly duty ticks
      end else if ((i_tbase + 10'h001) == s_q.dbuf && s_q.dbuf[9:2] < i_period) begin
        s_d.raw = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) s_q <= '0;
    else         s_q <= s_d;
  end

  assign o_out = s_q.raw ^ i_pol;

  AST_DISABLED_LOW: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_en |=> !s_q.raw) else $error("disabled channel not inactive");
  AST_WRAP_SET: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_en && i_run && i_reload && i_duty != 10'h000) |=> s_q.raw) else $error("wrap did not set output");
  AST_BUF_LOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_reload && !$past(i_reload)) |-> $stable(s_q.dbuf)) else $error("buffer changed off wrap");
  COV_CLEAR: cover property (@(posedge i_clk) s_q.raw ##1 !s_q.raw);
endmodule : tbpwm_chan
`default_nettype wire

// ==== testbench/tbpwm_sink.sv ====
// Pin-side consumer model that counts high cycles of each PWM output
`timescale 1ns/1ps
`default_nettype none
module tbpwm_sink (
  input  wire logic             i_clk,  // System clock
  input  wire logic             i_clr,  // Restart the count window
  input  wire logic [1:0]       i_pwm,  // Observed PWM levels
  output logic      [1:0][15:0] o_high  // High cycles seen per channel
);
  // Sums sampled levels; the pin is taken as an enabled output
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (i_clr) begin
        o_high[c] <= 16'h0000;
      end else begin
        o_high[c] <= o_high[c] + {15'h0000, i_pwm[c]};
      end
    end
  end
endmodule : tbpwm_sink
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the ten-bit PWM pair and its timer select register
`timescale 1ns/1ps
`default_nettype none
`include "tbpwm_map.svh"
module tb;
  logic             i_clk   = 1'b0;   // 250 MHz system clock
  logic             i_nrst  = 1'b0;   // Reset, active low
  logic             i_sleep = 1'b0;   // Sleep request
  logic             psel    = 1'b0;   // APB select
  logic             penable = 1'b0;   // APB enable
  logic             pwrite  = 1'b0;   // APB direction
  logic [11:0]      paddr   = 12'h000; // APB address
  logic [31:0]      pwdata  = 32'h00000000; // APB write data
  logic             pready;           // APB ready
  logic             pslverr;          // APB error
  logic [31:0]      prdata;           // APB read data
  logic [1:0]       ccp1;             // CCP1 pair select
  logic [1:0]       ccp2;             // CCP2 pair select
  logic [1:0]       pwm;              // PWM levels
  logic             clr     = 1'b0;   // Sink window restart
  logic [1:0][15:0] hi;               // Sink high counts
  logic [31:0]      rdv;              // Last read data
  logic             err;              // Last error flag
  int               error_cnt   = 0;  // Mismatches
  int               check_count = 0;  // Comparisons

  // Clock toggles every half period
  always #2 i_clk = ~i_clk;

  tbpwm_top #(.NCHAN(2)) i_tbpwm_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_sleep(i_sleep), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .o_ccp1_sel(ccp1), .o_ccp2_sel(ccp2), .o_pwm(pwm));
  tbpwm_sink i_tbpwm_sink (.i_clk(i_clk), .i_clr(clr), .i_pwm(pwm), .o_high(hi));

  // Compares one value and reports a mismatch
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // Look at the settled outputs mid-cycle: they are what the next rising edge samples
    @(negedge i_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("pready", 32'h1, {31'h0, pready});
    rdv = prdata;
    err = pslverr;
    // Edge at which pready is sampled high; release only after it
    @(posedge i_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  // Register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Register read compared under a mask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(nm, exp, rdv & m);
  endtask : rd_chk

  // Expected high cycles in one period from duty, period, prescale and inversion
  function automatic int exp_high(int duty, int per, int pre, int inv);
    int full;
    int h;
    full = 4 * (per + 1) * pre;
    h = ((duty >> 2) >= per) ? full : duty * pre;
    return inv ? full - h : h;
  endfunction : exp_high

  // Settles two periods, then counts high cycles over three periods of n cycles
  task automatic meas(input int ch, input int h, input int n);
    repeat (2 * n + 8) @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (3 * n) @(posedge i_clk);
    // Read the count once settled, then return to the rising edge
    @(negedge i_clk);
    chk("high_cycles", 3 * h, {16'h0000, hi[ch]});
    @(posedge i_clk);
  endtask : meas

  // Prints the verdict and ends the run
  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // Cuts a hang short well beyond the expected run length
  initial begin : watchdog
    repeat (60000) @(posedge i_clk);
    error_cnt++;
    summarize();
  end

  // Main sequence: reset values, refused access, timer selects, duty corners, sleep
  initial begin : main
    int pa, pb, pre, sel, dut, d6, per, ch, tsel;
    logic [1:0] lvl;
    void'($urandom(65));
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    rd_chk("timer_select", `TBPWM_OFS_TSEL, 32'h000000FF, 32'h00000055);
    chk("ccp1_sel", 32'h1, {30'h0, ccp1});
    rd_chk("ctrl0", `TBPWM_OFS_CTRL0, 32'h000000FF, 32'h00000000);
    rd_chk("unmapped", 12'hF20, 32'hFFFFFFFF, 32'h00000000);
    chk("slverr", 32'h1, {31'h0, err});
    pa  = 3 + $urandom % 14;
    pb  = 3 + $urandom % 14;
    pre = 1 + $urandom % 2;
    d6  = 0;
    wr(`TBPWM_OFS_DUTY1, pb << 24);
    wr(`TBPWM_OFS_DUTY0, pa << 24);
    // All three timers run at the same prescale, one field per timer
    wr(`TBPWM_OFS_TIMER_IF, (pre - 1) * 32'h00041040 | 32'h0000001C);
    // Cases: selects 00..11, full duty, zero duty, inverted, disabled
    for (int k = 0; k < 8; k++) begin
      ch   = k % 2;
      sel  = (k < 4) ? k : 1;
      per  = (sel == 2) ? pb : (sel == 3) ? 255 : pa;
      dut  = (k == 4) ? 4 * per + $urandom % 4 : (k == 5) ? 0 : $urandom % (4 * per);
      d6   = (k == 6) ? dut : d6;
      tsel = (sel << 6) | (sel << 4) | ($urandom % 16);
      wr(`TBPWM_OFS_TSEL, tsel);
      rd_chk("timer_select", `TBPWM_OFS_TSEL, 32'h000000FF, tsel);
      chk("ccp1_sel", tsel & 3, {30'h0, ccp1});
      chk("ccp2_sel", (tsel >> 2) & 3, {30'h0, ccp2});
      wr(ch ? `TBPWM_OFS_DUTY1 : `TBPWM_OFS_DUTY0, ((ch ? pb : pa) << 24) | (dut << 6));
      wr(ch ? `TBPWM_OFS_CTRL1 : `TBPWM_OFS_CTRL0, ((k != 7) << 7) | ((k == 6) << 4));
      wr(ch ? `TBPWM_OFS_CTRL0 : `TBPWM_OFS_CTRL1, 32'h00000000);
      meas(ch, (k != 7) ? exp_high(dut, per, pre, k == 6) : 0, 4 * (per + 1) * pre);
      if (k == 4 || k == 5) begin
        rd_chk("out_level", ch ? `TBPWM_OFS_CTRL1 : `TBPWM_OFS_CTRL0, 32'h20, (k == 4) ? 32'h20 : 32'h0);
      end
    end
    // Sleep freezes the level; counting resumes on wake-up
    wr(`TBPWM_OFS_CTRL0, 32'h00000080);
    repeat (4 * (pa + 1) * pre * 3 + 5) @(posedge i_clk);
    i_sleep <= 1'b1;
    repeat (8) @(posedge i_clk);
    lvl = pwm;
    meas(0, lvl[0] ? 4 * (pa + 1) * pre : 0, 4 * (pa + 1) * pre);
    i_sleep <= 1'b0;
    meas(0, exp_high(d6, pa, pre, 0), 4 * (pa + 1) * pre);
    summarize();
  end
endmodule : tb
`default_nettype wire
